// >>> sdc_defines.svh
// Constants for the SDRAM command pin interface: field positions, widths, command codes
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// ****************************************************************
// Widths of the pin groups
// ****************************************************************
`define SDC_ADDR_W 12
`define SDC_COL_W 9
`define SDC_BANK_W 2
`define SDC_NUM_BANKS 4
`define SDC_DATA_W 16
`define SDC_MASK_W 2

// ****************************************************************
// Field positions on the address inputs
// ****************************************************************
`define SDC_PRE_SEL_BIT 10
`define SDC_COL_MSB 8

// ****************************************************************
// Command codes on {row strobe, column strobe, write enable}, active low
// ****************************************************************
`define SDC_CODE_ACT 3'h3
`define SDC_CODE_PRE 3'h2
`define SDC_CODE_RD 3'h5
`define SDC_CODE_WR 3'h4
`define SDC_CODE_MRS 3'h0
`define SDC_CODE_REF 3'h1
`define SDC_CODE_BST 3'h6
`define SDC_CODE_NOP 3'h7

// ****************************************************************
// Reset values
// ****************************************************************
`define SDC_MODE_RESET 12'h000
`define SDC_ROW_RESET 12'h000

`endif

// >>> sdc_pkg.sv
// Types shared by the SDRAM command pin interface modules
package sdc_pkg;
`include "sdc_defines.svh"

    // ****************************************************************
    // Decoded commands
    // ****************************************************************
    typedef enum logic [2:0] {
        SDC_CMD_NOP = 3'h0,
        SDC_CMD_ACT = 3'h1,
        SDC_CMD_PRE = 3'h2,
        SDC_CMD_RD = 3'h3,
        SDC_CMD_WR = 3'h4,
        SDC_CMD_MRS = 3'h5,
        SDC_CMD_REF = 3'h6,
        SDC_CMD_BST = 3'h7
    } sdc_cmd_e;

    // Per-bank state
    typedef enum logic {
        SDC_BANK_IDLE = 1'b0,
        SDC_BANK_ACTIVE = 1'b1
    } sdc_bank_e;

    // One column access handed to the array side
    typedef struct packed {
        logic is_write;
        logic auto_precharge;
        logic [`SDC_BANK_W-1:0] bank;
        logic [`SDC_ADDR_W-1:0] row;
        logic [`SDC_COL_W-1:0] col;
        logic [`SDC_DATA_W-1:0] data;
        logic [`SDC_MASK_W-1:0] byte_en;
    } sdc_access_s;

endpackage : sdc_pkg

// >>> sdc_acc_if.sv
// Valid/ready channel carrying column accesses between the decoder and the buffer
`timescale 1ns/100ps
interface sdc_acc_if;
    import sdc_pkg::*;
    logic valid; // Access offered
    logic ready; // Receiver can take it
    sdc_access_s data; // Access payload
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface : sdc_acc_if

// >>> sdc_acc_buf.sv
// Two-entry access buffer between the command decoder and the array side
`timescale 1ns/100ps
module sdc_acc_buf
    import sdc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Filling side
    sdc_acc_if.snk push,
    // Draining side
    sdc_acc_if.src pop
);

    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    sdc_access_s mem [2]; // Entries, flip-flops
    logic wr_ptr; // Next entry to fill
    logic rd_ptr; // Next entry to drain
    logic [1:0] count; // Entries held, 0..2
    logic do_push; // Entry written this cycle
    logic do_pop; // Entry taken this cycle

    // Honest full and empty flags
    assign push.ready = (count != 2'h2);
    assign pop.valid = (count != 2'h0);
    assign pop.data = mem[rd_ptr];
    assign do_push = push.valid & push.ready;
    assign do_pop = pop.valid & pop.ready;

    // Entry write
    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_ptr] <= push.data;
        end
    end

    // Pointers and occupancy; push and pop together keep the count
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (do_push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (do_pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (do_push && !do_pop) begin
                count <= count + 2'h1;
            end else if (do_pop && !do_push) begin
                count <= count - 2'h1;
            end
        end
    end

endmodule : sdc_acc_buf

// >>> sdc_cmd_pins.sv
// SDRAM command, address and data pin interface: decoder, bank state and data pins
// Operation
// - Activate captures row from all twelve addresses
// - Column from low nine; bit ten selects autoprecharge
// - Precharge bit ten high means all banks
// - Mode register set loads opcode from addresses
// - Chip select high masks every command
// - Strobes and write enable form command code
// - Activate puts addressed bank into active state
// - Precharge returns target bank to idle
// - Column strobe low starts read or write access
// - Write enable high reads, low writes
// - Byte masks disable output bytes, block writes
// - Sixteen-bit data moves on rising clock edges
`timescale 1ns/100ps
module sdc_cmd_pins
    import sdc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Command pins from the memory controller
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [`SDC_BANK_W-1:0] bank_select,
    input wire logic [`SDC_ADDR_W-1:0] address_inputs,
    input wire logic lower_byte_mask,
    input wire logic upper_byte_mask,
    // Bidirectional data bus, split into three signals
    input wire logic [`SDC_DATA_W-1:0] data_bus_in,
    output logic [`SDC_DATA_W-1:0] data_bus_out,
    output logic [`SDC_MASK_W-1:0] data_bus_oe,
    // Access stream to the array side
    output logic acc_valid,
    input wire logic acc_ready,
    output logic acc_write,
    output logic acc_auto_precharge,
    output logic [`SDC_BANK_W-1:0] acc_bank,
    output logic [`SDC_ADDR_W-1:0] acc_row,
    output logic [`SDC_COL_W-1:0] acc_col,
    output logic [`SDC_DATA_W-1:0] acc_data,
    output logic [`SDC_MASK_W-1:0] acc_byte_en,
    // Read data returning from the array side
    input wire logic rd_valid,
    input wire logic [`SDC_DATA_W-1:0] rd_data,
    // Status
    output logic [`SDC_NUM_BANKS-1:0] bank_active,
    output logic [`SDC_ADDR_W-1:0] mode_opcode,
    output logic access_dropped
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int PIN_W = 4 + `SDC_BANK_W + `SDC_ADDR_W + 2 + `SDC_DATA_W;

    logic [PIN_W-1:0] pin_meta; // First stage, read only by second
    logic [PIN_W-1:0] pin_sync; // Second stage, safe to decode

    // Two flops on every pin; the controller is treated as another domain
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_meta <= '1;
            pin_sync <= '1;
        end else begin
            pin_meta <= {cs_n, ras_n, cas_n, we_n, bank_select, address_inputs,
                         upper_byte_mask, lower_byte_mask, data_bus_in};
            pin_sync <= pin_meta;
        end
    end

    // Unpacked view of the synchronised pins
    logic s_cs_n; // Chip select
    logic [2:0] s_code; // Row strobe, column strobe, write enable
    logic [`SDC_BANK_W-1:0] s_bank; // Bank select
    logic [`SDC_ADDR_W-1:0] s_addr; // Address inputs
    logic [`SDC_MASK_W-1:0] s_mask; // {upper, lower} byte masks
    logic [`SDC_DATA_W-1:0] s_data; // Write data

    assign {s_cs_n, s_code, s_bank, s_addr, s_mask, s_data} = pin_sync;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    sdc_cmd_e cmd; // Decoded command this cycle

    // Chip select high turns any code into a no-operation
    always_comb begin
        cmd = SDC_CMD_NOP;
        if (!s_cs_n) begin
            unique case (s_code)
                `SDC_CODE_ACT: cmd = SDC_CMD_ACT;
                `SDC_CODE_PRE: cmd = SDC_CMD_PRE;
                `SDC_CODE_RD: cmd = SDC_CMD_RD;
                `SDC_CODE_WR: cmd = SDC_CMD_WR;
                `SDC_CODE_MRS: cmd = SDC_CMD_MRS;
                `SDC_CODE_REF: cmd = SDC_CMD_REF;
                `SDC_CODE_BST: cmd = SDC_CMD_BST;
                `SDC_CODE_NOP: cmd = SDC_CMD_NOP;
            endcase
        end
    end

    // Common fields of the decoded command
    logic pre_sel; // Address bit ten
    logic [`SDC_COL_W-1:0] col_addr; // Low nine address bits
    logic col_cmd; // Read or write this cycle
    logic col_hit; // Column access to an open bank

    assign pre_sel = s_addr[`SDC_PRE_SEL_BIT];
    assign col_addr = s_addr[`SDC_COL_MSB:0];
    assign col_cmd = (cmd == SDC_CMD_RD) || (cmd == SDC_CMD_WR);
    assign col_hit = col_cmd && bank_active[s_bank];

    // ****************************************************************
    // Bank state, one copy per bank
    // ****************************************************************
    logic [`SDC_ADDR_W-1:0] open_row [`SDC_NUM_BANKS]; // Row held open per bank

    genvar gb;
    generate
        for (gb = 0; gb < `SDC_NUM_BANKS; gb++) begin : g_bank
            sdc_bank_e state; // Idle or active
            logic addressed; // Command names this bank

            assign addressed = (s_bank == `SDC_BANK_W'(gb));
            assign bank_active[gb] = (state == SDC_BANK_ACTIVE);

            // Activation opens, precharge or auto precharge closes
            always_ff @(posedge mclk) begin
                if (rst) begin
                    state <= SDC_BANK_IDLE;
                end else if (cmd == SDC_CMD_ACT && addressed) begin
                    state <= SDC_BANK_ACTIVE;
                end else if (cmd == SDC_CMD_PRE && (pre_sel || addressed)) begin
                    state <= SDC_BANK_IDLE;
                end else if (col_hit && addressed && pre_sel) begin
                    state <= SDC_BANK_IDLE;
                end
            end

            // Row captured from all address inputs on activation of an idle bank
            always_ff @(posedge mclk) begin
                if (rst) begin
                    open_row[gb] <= `SDC_ROW_RESET;
                end else if (cmd == SDC_CMD_ACT && addressed
                             && state == SDC_BANK_IDLE) begin
                    open_row[gb] <= s_addr;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Mode settings
    // ****************************************************************
    // Only taken with every bank idle, as the command is legal only then
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_opcode <= `SDC_MODE_RESET;
        end else if (cmd == SDC_CMD_MRS && bank_active == '0) begin
            mode_opcode <= s_addr;
        end
    end

    // ****************************************************************
    // Column access stream through the two-entry buffer
    // ****************************************************************
    sdc_acc_if push_ch ();
    sdc_acc_if pop_ch ();

    // Offer one access per column command to an open bank
    always_ff @(posedge mclk) begin
        if (rst) begin
            push_ch.valid <= 1'b0;
        end else begin
            push_ch.valid <= col_hit;
        end
    end

    // Payload; byte masks clear the write enables of their bytes
    always_ff @(posedge mclk) begin
        push_ch.data.is_write <= (cmd == SDC_CMD_WR);
        push_ch.data.auto_precharge <= pre_sel;
        push_ch.data.bank <= s_bank;
        push_ch.data.row <= open_row[s_bank];
        push_ch.data.col <= col_addr;
        push_ch.data.data <= s_data;
        push_ch.data.byte_en <= ~s_mask;
    end

    // A full buffer cannot stall the pins, so the loss is flagged instead
    always_ff @(posedge mclk) begin
        if (rst) begin
            access_dropped <= 1'b0;
        end else begin
            access_dropped <= push_ch.valid & ~push_ch.ready;
        end
    end

    sdc_acc_buf u_buf (
        .mclk(mclk),
        .rst(rst),
        .push(push_ch.snk),
        .pop(pop_ch.src)
    );

    // Draining side onto the plain ports; the array side may stall
    assign acc_valid = pop_ch.valid;
    assign pop_ch.ready = acc_ready;
    assign acc_write = pop_ch.data.is_write;
    assign acc_auto_precharge = pop_ch.data.auto_precharge;
    assign acc_bank = pop_ch.data.bank;
    assign acc_row = pop_ch.data.row;
    assign acc_col = pop_ch.data.col;
    assign acc_data = pop_ch.data.data;
    assign acc_byte_en = pop_ch.data.byte_en;

    // ****************************************************************
    // Read data onto the bus
    // ****************************************************************
    // One word per returned read; a masked byte keeps its driver off
    always_ff @(posedge mclk) begin
        if (rst) begin
            data_bus_out <= '0;
            data_bus_oe <= '0;
        end else if (rd_valid) begin
            data_bus_out <= rd_data;
            data_bus_oe <= ~s_mask;
        end else begin
            data_bus_oe <= '0;
        end
    end

endmodule : sdc_cmd_pins

// >>> sdc_pins_asserts.sv
// Concurrent checks on the ports of the pin interface
`timescale 1ns/100ps
`include "sdc_defines.svh"
module sdc_pins_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Command pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [`SDC_BANK_W-1:0] bank_select,
    input wire logic [`SDC_ADDR_W-1:0] address_inputs,
    input wire logic lower_byte_mask,
    input wire logic upper_byte_mask,
    input wire logic [`SDC_DATA_W-1:0] data_bus_in,
    // Outputs watched
    input wire logic [`SDC_DATA_W-1:0] data_bus_out,
    input wire logic [`SDC_MASK_W-1:0] data_bus_oe,
    input wire logic acc_valid,
    input wire logic acc_ready,
    input wire logic acc_write,
    input wire logic acc_auto_precharge,
    input wire logic [`SDC_COL_W-1:0] acc_col,
    input wire logic [`SDC_DATA_W-1:0] acc_data,
    input wire logic [`SDC_MASK_W-1:0] acc_byte_en,
    input wire logic rd_valid,
    input wire logic [`SDC_DATA_W-1:0] rd_data,
    input wire logic [`SDC_NUM_BANKS-1:0] bank_active,
    input wire logic [`SDC_ADDR_W-1:0] mode_opcode
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Pin decode; the design answers three edges later because of its synchronisers
    logic [2:0] code;
    logic act;
    logic pre;
    logic mrs;
    logic rdwr;
    assign code = {ras_n, cas_n, we_n};
    assign act = !cs_n && code == `SDC_CODE_ACT;
    assign pre = !cs_n && code == `SDC_CODE_PRE;
    assign mrs = !cs_n && code == `SDC_CODE_MRS;
    assign rdwr = !cs_n && (code == `SDC_CODE_RD || code == `SDC_CODE_WR);
    property p_act;
        logic [1:0] b;
        (act, b = bank_select) |-> ##3 bank_active[b];
    endproperty
    property p_pre_one;
        logic [1:0] b;
        (pre && !address_inputs[10], b = bank_select) |-> ##3 !bank_active[b];
    endproperty
    property p_mrs;
        logic [11:0] op;
        (mrs, op = address_inputs) |-> ##3 (mode_opcode == op || bank_active != 4'h0);
    endproperty
    // Quiet history keeps the buffer empty and the bank state settled
    property p_col;
        logic [8:0] c; logic ap; logic w; logic [15:0] d; logic [1:0] m;
        (rdwr && bank_active[bank_select] && !acc_valid && $past(cs_n) && $past(cs_n, 2)
            && $past(cs_n, 3), c = address_inputs[8:0], ap = address_inputs[10],
            w = !we_n, d = data_bus_in, m = ~{upper_byte_mask, lower_byte_mask})
        |-> ##4 acc_valid && acc_col == c && acc_auto_precharge == ap && acc_write == w
            && acc_byte_en == m && (!w || acc_data == d);
    endproperty
    act_opens_a: assert property (p_act)
        else $error("activate did not open the bank");
    pre_one_a: assert property (p_pre_one)
        else $error("precharge left the bank open");
    pre_all_a: assert property (pre && address_inputs[10] |-> ##3 bank_active == 4'h0)
        else $error("precharge all left a bank open");
    mode_load_a: assert property (p_mrs)
        else $error("mode opcode not loaded");
    quiet_cmd_a: assert property ((cs_n || code inside {`SDC_CODE_NOP, `SDC_CODE_BST,
        `SDC_CODE_REF}) |-> ##3 $stable(bank_active) && $stable(mode_opcode))
        else $error("ignored command changed state");
    col_fields_a: assert property (p_col)
        else $error("column access fields wrong");
    acc_hold_a: assert property (acc_valid && !acc_ready |=> acc_valid && $stable(acc_col)
        && $stable(acc_data) && $stable(acc_write))
        else $error("stalled access changed");
    rd_word_a: assert property (rd_valid |=> data_bus_out == $past(rd_data))
        else $error("read word not driven");
    oe_pulse_a: assert property (!rd_valid |=> data_bus_oe == 2'h0)
        else $error("data bus driven without read word");
    cover property (act);
    cover property (mrs);
    cover property (pre && address_inputs[10]);
endmodule : sdc_pins_chk

bind sdc_cmd_pins sdc_pins_chk u_chk (
    .mclk(mclk), .rst(rst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select(bank_select), .address_inputs(address_inputs),
    .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
    .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_write(acc_write),
    .acc_auto_precharge(acc_auto_precharge), .acc_col(acc_col), .acc_data(acc_data),
    .acc_byte_en(acc_byte_en), .rd_valid(rd_valid), .rd_data(rd_data),
    .bank_active(bank_active), .mode_opcode(mode_opcode)
);

// >>> sdc_ctl_model.sv
// Behavioural memory controller driving the command, address and data pins
`timescale 1ns/100ps
`include "sdc_defines.svh"
module sdc_ctl_model (
    // Clock
    input wire logic mclk,
    // Command pins
    output logic [3:0] cmd,
    output logic [`SDC_BANK_W-1:0] bank_select,
    output logic [`SDC_ADDR_W-1:0] address_inputs,
    output logic [`SDC_MASK_W-1:0] masks,
    // Write data and its drive enable
    output logic [`SDC_DATA_W-1:0] dq_drv,
    output logic dq_en
);
    // Deselected at power up
    initial begin
        cmd = 4'hf;
        bank_select = 2'h0;
        address_inputs = 12'h000;
        masks = 2'h0;
        dq_drv = 16'h0000;
        dq_en = 1'b0;
    end
    // One command {cs_n, ras_n, cas_n, we_n} per cycle, held over the rising edge
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
        input logic [1:0] m, input logic [15:0] d);
        @(negedge mclk);
        cmd = c;
        bank_select = b;
        address_inputs = a;
        masks = m;
        dq_drv = d;
        dq_en = (c == {1'b0, `SDC_CODE_WR});
    endtask : issue
    // Deselect; lines no longer meaningful keep moving so stale values never match
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge mclk);
            cmd = {1'b1, ~cmd[2:0]};
            bank_select = ~bank_select;
            address_inputs = ~address_inputs;
            dq_drv = ~dq_drv;
            dq_en = 1'b0;
        end
    endtask : idle
endmodule : sdc_ctl_model

// >>> tb.sv
// Self-checking bench for the pin interface
`timescale 1ns/100ps
`include "sdc_defines.svh"
`define CHK(nm, ex, got) \
    checks_done++; \
    if ((got) !== (ex)) begin \
        $display("[ERR] %s exp %h got %h", nm, ex, got); \
        fails++; \
    end
module tb;
    localparam logic [3:0] C_ACT = {1'b0, `SDC_CODE_ACT};
    localparam logic [3:0] C_PRE = {1'b0, `SDC_CODE_PRE};
    localparam logic [3:0] C_RD = {1'b0, `SDC_CODE_RD};
    localparam logic [3:0] C_WR = {1'b0, `SDC_CODE_WR};
    localparam logic [3:0] C_MRS = {1'b0, `SDC_CODE_MRS};
    localparam logic [3:0] C_NOP = {1'b0, `SDC_CODE_NOP};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic acc_ready = 1'b0;
    logic rd_valid = 1'b0;
    logic [15:0] rd_data = 16'h0000;
    logic seen_drop = 1'b0;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    wire [3:0] cmd;
    wire [1:0] bsel, masks, data_bus_oe, acc_bank, acc_byte_en;
    wire [11:0] addr, acc_row, mode_opcode;
    wire [15:0] dq_drv, data_in, data_bus_out, acc_data;
    wire [8:0] acc_col;
    wire [3:0] bank_active;
    wire dq_en, acc_valid, acc_write, acc_ap, access_dropped;
    // Shared data wire: controller on writes, device on read words, else moving
    assign data_in = dq_en ? dq_drv : (|data_bus_oe ? data_bus_out : ~dq_drv);
    initial forever #25 mclk = ~mclk;
    sdc_ctl_model u_ctl (.mclk(mclk), .cmd(cmd), .bank_select(bsel), .address_inputs(addr),
        .masks(masks), .dq_drv(dq_drv), .dq_en(dq_en));
    sdc_cmd_pins uut (.mclk(mclk), .rst(rst), .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]),
        .we_n(cmd[0]), .bank_select(bsel), .address_inputs(addr), .lower_byte_mask(masks[0]),
        .upper_byte_mask(masks[1]), .data_bus_in(data_in), .data_bus_out(data_bus_out),
        .data_bus_oe(data_bus_oe), .acc_valid(acc_valid), .acc_ready(acc_ready),
        .acc_write(acc_write), .acc_auto_precharge(acc_ap), .acc_bank(acc_bank),
        .acc_row(acc_row), .acc_col(acc_col), .acc_data(acc_data), .acc_byte_en(acc_byte_en),
        .rd_valid(rd_valid), .rd_data(rd_data), .bank_active(bank_active),
        .mode_opcode(mode_opcode), .access_dropped(access_dropped));
    // Cycle ceiling and a latch for the one-cycle drop pulse
    always @(posedge mclk) begin
        cycles++;
        if (access_dropped === 1'b1) seen_drop <= 1'b1;
        if (cycles == 4000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic t_banks();
        for (int b = 0; b < 4; b++) u_ctl.issue(C_ACT, b[1:0], 12'h0a5, 2'h0, 16'h0);
        u_ctl.idle(4);
        `CHK("open all", 4'hf, bank_active)
        u_ctl.issue(C_PRE, 2'h2, 12'h3ff, 2'h0, 16'h0);
        u_ctl.issue({1'b1, C_PRE[2:0]}, 2'h0, 12'h400, 2'h0, 16'h0);
        u_ctl.idle(4);
        `CHK("close one", 4'hb, bank_active)
        u_ctl.issue(C_PRE, 2'h0, 12'h400, 2'h0, 16'h0);
        u_ctl.idle(4);
        `CHK("close all", 4'h0, bank_active)
    endtask : t_banks
    task automatic t_mode();
        u_ctl.issue(C_MRS, 2'h0, 12'h2a5, 2'h0, 16'h0);
        for (int c = 5; c < 8; c++) u_ctl.issue({1'b0, c[2:0]}, 2'h1, 12'h0, 2'h0, 16'h0);
        u_ctl.issue(C_ACT, 2'h3, 12'h001, 2'h0, 16'h0);
        u_ctl.issue(C_MRS, 2'h0, 12'h3ff, 2'h0, 16'h0);
        u_ctl.idle(4);
        `CHK("mode kept", 12'h2a5, mode_opcode)
        `CHK("one open", 4'h8, bank_active)
        u_ctl.issue(C_PRE, 2'h0, 12'h400, 2'h0, 16'h0);
    endtask : t_mode
    task automatic t_col();
        u_ctl.issue(C_ACT, 2'h1, 12'h123, 2'h0, 16'h0);
        u_ctl.issue(C_ACT, 2'h2, 12'h0ff, 2'h0, 16'h0);
        u_ctl.idle(3);
        u_ctl.issue(C_WR, 2'h1, 12'h9ab, 2'h1, 16'hbeef);
        u_ctl.issue(C_RD, 2'h1, 12'h4ff, 2'h0, 16'h0);
        u_ctl.issue(C_RD, 2'h2, 12'h011, 2'h0, 16'h0);
        u_ctl.idle(6);
        `CHK("overflow", 1'b1, seen_drop)
        `CHK("auto close", 4'h4, bank_active)
        `CHK("head kind", 1'b1, acc_write)
        `CHK("head col", 9'h1ab, acc_col)
        `CHK("head row", {2'h1, 12'h123}, {acc_bank, acc_row})
        `CHK("head data", 18'h2beef, {acc_byte_en, acc_data})
        acc_ready = 1'b1;
        @(negedge mclk);
        `CHK("next access", 11'h2ff, {acc_write, acc_ap, acc_col})
        @(negedge mclk);
        `CHK("drained", 1'b0, acc_valid)
        acc_ready = 1'b0;
        u_ctl.issue(C_PRE, 2'h0, 12'h400, 2'h0, 16'h0);
    endtask : t_col
    task automatic t_rd();
        u_ctl.issue(C_NOP, 2'h0, 12'h0, 2'h2, 16'h0);
        u_ctl.idle(3);
        rd_valid = 1'b1;
        rd_data = 16'hc3a5;
        @(negedge mclk);
        rd_valid = 1'b0;
        `CHK("read word", 16'hc3a5, data_in)
        `CHK("read enables", 2'h1, data_bus_oe)
        @(negedge mclk);
        `CHK("enable pulse", 2'h0, data_bus_oe)
    endtask : t_rd
    task automatic report_and_stop();
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        t_banks();
        t_mode();
        t_col();
        t_rd();
        report_and_stop();
    end
endmodule : tb
